// [ofc_host_model.sv]
/*
  host side of the octal link: link clock, chip select, command bytes,
  and capture of the two-byte answer.
  assumes a 100 ns system clock; link clock is still between frames.
*/
`timescale 1ns/1ps

module ofc_host_model #(
  parameter int HALF = 4
) (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_dq,
  input  wire logic       i_dq_oe_n,
  output logic            o_ck,
  output logic            o_cs_n,
  output logic      [7:0] o_dq
);

  initial
  begin
    o_ck   = 1'b0;
    o_cs_n = 1'b1;
    o_dq   = 8'hA5;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // answer sampled with a slow link phase; undriven bytes read as x
  task automatic grab(output logic [7:0] b);
    tick(2 * HALF);
    b = i_dq_oe_n ? 8'hXX : i_dq;
  endtask

  // exact cycle count, one per frame
  task automatic txn(
    input  logic [7:0]  op,
    input  logic [7:0]  arg,
    input  int          ncyc,
    input  logic [15:0] data,
    input  logic        rd,
    output logic [15:0] rsp
  );
    rsp = 16'h0000;
    @(posedge i_clk_sys);
    o_cs_n <= 1'b0;
    tick(3);
    for (int i = 0; i < ncyc; i++)
    begin
      o_dq <= (i == 0) ? op : data[15:8];
      o_ck <= 1'b1;
      tick(HALF);
      o_dq <= (i == 0) ? arg : data[7:0];
      o_ck <= 1'b0;
      tick(HALF);
    end
    // released line shows the inverse, never a stale byte
    o_dq <= ~o_dq;
    if (rd)
    begin
      grab(rsp[15:8]);
      o_ck <= 1'b1;
      grab(rsp[7:0]);
      o_ck <= 1'b0;
    end
    tick(2 * HALF);
    o_cs_n <= 1'b1;
    tick(HALF);
  endtask

endmodule // ofc_host_model

// [ofc_pkg.sv]
/*
  constants, encodings and the state record of the octal transaction
  decoder. assumes the decoder and the bench are the only users; nothing here is
  clocked.
*/
package ofc_pkg;

  // transaction opcodes, first byte of the first command word
  localparam logic [7:0] OP_ARRAY_READ   = 8'h01;
  localparam logic [7:0] OP_ENTER_SPI    = 8'h02;
  localparam logic [7:0] OP_SOFT_RESET   = 8'h03;
  localparam logic [7:0] OP_DEEP_SLEEP   = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_FLAG_CLEAR   = 8'h06;
  localparam logic [7:0] OP_POR_WRITE    = 8'h07;
  localparam logic [7:0] OP_POR_READ     = 8'h08;
  localparam logic [7:0] OP_ICFG_WRITE   = 8'h09;
  localparam logic [7:0] OP_ICFG_READ    = 8'h0A;
  localparam logic [7:0] OP_ISTAT_WRITE  = 8'h0B;
  localparam logic [7:0] OP_ISTAT_READ   = 8'h0C;
  localparam logic [7:0] OP_VCFGA_WRITE  = 8'h0D;
  localparam logic [7:0] OP_VCFGB_WRITE  = 8'h0E;
  localparam logic [7:0] OP_VCFGA_READ   = 8'h0F;
  localparam logic [7:0] OP_VCFGB_READ   = 8'h10;

  // command cycle counts
  localparam logic [2:0] CYC_ONE   = 3'h1;
  localparam logic [2:0] CYC_TWO   = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR  = 3'h4;
  localparam logic [2:0] CYC_NONE  = 3'h0;

  // status register zero masks
  localparam logic [7:0] SR0_SRST_CLR  = 8'h3B;
  localparam logic [7:0] SR0_FAIL_MASK = 8'h38;

  // values after reset
  localparam logic [7:0]  RST_SR0       = 8'h00;
  localparam logic [15:0] RST_POR_TIMER = 16'h0000;
  localparam logic [15:0] RST_ICFG      = 16'h0000;
  localparam logic [15:0] RST_ISTAT     = 16'h0000;
  localparam logic [15:0] RST_VCFG_A    = 16'h0000;
  localparam logic [15:0] RST_VCFG_B    = 16'h0000;
  localparam logic        RST_CTRL_EN   = 1'b1;

  // apb byte offsets
  localparam logic [11:0] A_IRQ_STS  = 12'h000;
  localparam logic [11:0] A_IRQ_CLR  = 12'h004;
  localparam logic [11:0] A_IRQ_EN   = 12'h008;
  localparam logic [11:0] A_CTRL     = 12'h00C;
  localparam logic [11:0] A_MODE     = 12'h010;
  localparam logic [11:0] A_POR      = 12'h014;
  localparam logic [11:0] A_ICFG     = 12'h018;
  localparam logic [11:0] A_ISTAT    = 12'h01C;
  localparam logic [11:0] A_VCFG_A   = 12'h020;
  localparam logic [11:0] A_VCFG_B   = 12'h024;

  // interrupt event bits and control bits
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_BADOP = 1;
  localparam int IRQ_MODE  = 2;
  localparam int IRQ_SRST  = 3;
  localparam int IRQ_W     = 4;
  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_RELEASE_BIT = 1;

  // power-on timer tick bounds, in ns and in system clocks
  localparam int CLK_PERIOD_NS     = 100;
  localparam int POR_TICK_MIN_NS   = 25000;
  localparam int POR_TICK_MAX_NS   = 42000;
  localparam int POR_TICK_MIN_CYC  =
    (POR_TICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_TICK_MAX_CYC  = POR_TICK_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    LNK_IDLE = 4'b0001,
    LNK_CMD  = 4'b0010,
    LNK_RESP = 4'b0100,
    LNK_WAIT = 4'b1000
  } ofc_lnk_e;

  typedef enum logic [3:0] {
    MODE_OCTAL   = 4'b0001,
    MODE_OVERLAY = 4'b0010,
    MODE_SPI     = 4'b0100,
    MODE_SLEEP   = 4'b1000
  } ofc_mode_e;

  typedef struct packed {
    logic [2:0]        ck_sync;
    logic [1:0]        cs_sync;
    logic [7:0]        dq_s0;
    logic [7:0]        dq_s1;
    ofc_lnk_e          lnk;
    ofc_mode_e         mode;
    logic [7:0]        hi_byte;
    logic [2:0]        cyc;
    logic [7:0]        op;
    logic [7:0]        arg;
    logic [15:0]       rsp;
    logic              rsp_pend;
    logic              rsp_lo;
    logic [7:0]        dq_out;
    logic              dq_oe_n;
    logic [7:0]        arr_addr;
    logic              arr_ovl;
    logic              ex_done;
    logic [7:0]        ex_op;
    logic [15:0]       ex_word;
    logic [7:0]        sr0;
    logic [15:0]       por_timer;
    logic [15:0]       icfg;
    logic [15:0]       istat;
    logic [15:0]       vcfg_a;
    logic [15:0]       vcfg_b;
    logic              ctrl_en;
    logic [IRQ_W-1:0]  irq_sts;
    logic [IRQ_W-1:0]  irq_en;
    logic [31:0]       prdata;
    logic              pslverr;
    logic              irq;
  } ofc_state_s;

endpackage

// [ofc_txn_decoder.sv]
/*
  octal ddr transaction decoder of a serial flash, with apb register
  access and one level interrupt.
  assumes the link clock, chip select and data lines arrive from the
  host pins, slow against i_clk_sys, and that the array answers within the
  i_clk_sys cycle in which o_array_addr changes.
*/
`timescale 1ns/1ps

module ofc_txn_decoder (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_ck,
  input  wire logic        i_cs_n,
  input  wire logic [7:0]  i_dq,
  output logic      [7:0]  o_dq,
  output logic             o_dq_oe_n,
  output logic      [7:0]  o_array_addr,
  output logic             o_array_overlay,
  input  wire logic [15:0] i_array_data,
  input  wire logic [7:0]  i_sr0_set,
  input  wire logic        i_overlay_enter,
  output logic             o_spi_mode,
  output logic             o_deep_sleep,
  output logic             o_overlay,
  output logic      [7:0]  o_sr0,
  output logic      [15:0] o_poweron_timer,
  output logic      [15:0] o_vcfg_a,
  output logic      [15:0] o_vcfg_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq
);

  ofc_pkg::ofc_state_s s_q;
  ofc_pkg::ofc_state_s s_d;

  logic                     ck_rise;
  logic                     ck_fall;
  logic                     cs_hi;
  logic                     active;
  logic [7:0]               op_now;
  logic [2:0]               need;
  logic [2:0]               cyc_inc;
  logic [15:0]              word;
  logic [7:0]               sr0_clr;
  logic [ofc_pkg::IRQ_W-1:0] evt;
  logic [ofc_pkg::IRQ_W-1:0] irq_clr;
  logic                     apb_wr;

  function automatic logic [2:0] cycles_of(input logic [7:0] op);
    case (op)
      ofc_pkg::OP_ARRAY_READ,
      ofc_pkg::OP_SOFT_RESET,
      ofc_pkg::OP_FLAG_CLEAR:  cycles_of = ofc_pkg::CYC_ONE;
      ofc_pkg::OP_STATUS_READ: cycles_of = ofc_pkg::CYC_TWO;
      ofc_pkg::OP_ENTER_SPI,
      ofc_pkg::OP_DEEP_SLEEP:  cycles_of = ofc_pkg::CYC_THREE;
      ofc_pkg::OP_POR_WRITE,  ofc_pkg::OP_POR_READ,
      ofc_pkg::OP_ICFG_WRITE, ofc_pkg::OP_ICFG_READ,
      ofc_pkg::OP_ISTAT_WRITE, ofc_pkg::OP_ISTAT_READ,
      ofc_pkg::OP_VCFGA_WRITE, ofc_pkg::OP_VCFGB_WRITE,
      ofc_pkg::OP_VCFGA_READ, ofc_pkg::OP_VCFGB_READ:
        cycles_of = ofc_pkg::CYC_FOUR;
      default: cycles_of = ofc_pkg::CYC_NONE;
    endcase
  endfunction

  // read mux: bit 32 flags an unmapped or misaligned address
  function automatic logic [32:0] rd_mux(
    input logic [11:0]       addr,
    input ofc_pkg::ofc_state_s s
  );
    logic [32:0] r;
    r = {1'b0, 32'h00000000};
    case (addr)
      ofc_pkg::A_IRQ_STS: r[ofc_pkg::IRQ_W-1:0] = s.irq_sts;
      ofc_pkg::A_IRQ_CLR: r[31:0] = 32'h00000000;
      ofc_pkg::A_IRQ_EN:  r[ofc_pkg::IRQ_W-1:0] = s.irq_en;
      ofc_pkg::A_CTRL:    r[ofc_pkg::CTRL_EN_BIT] = s.ctrl_en;
      ofc_pkg::A_MODE:    r[15:0] = {s.sr0, 4'h0, s.mode};
      ofc_pkg::A_POR:     r[15:0] = s.por_timer;
      ofc_pkg::A_ICFG:    r[15:0] = s.icfg;
      ofc_pkg::A_ISTAT:   r[15:0] = s.istat;
      ofc_pkg::A_VCFG_A:  r[15:0] = s.vcfg_a;
      ofc_pkg::A_VCFG_B:  r[15:0] = s.vcfg_b;
      default:            r[32] = 1'b1;
    endcase
    rd_mux = r;
  endfunction

  always_comb
  begin
    s_d = s_q;
    // first sync stage feeds only the second
    s_d.ck_sync = {s_q.ck_sync[1], s_q.ck_sync[0], i_ck};
    s_d.cs_sync = {s_q.cs_sync[0], i_cs_n};
    s_d.dq_s0   = i_dq;
    s_d.dq_s1   = s_q.dq_s0;
    ck_rise = s_q.ck_sync[1] & ~s_q.ck_sync[2];
    ck_fall = ~s_q.ck_sync[1] & s_q.ck_sync[2];
    cs_hi   = s_q.cs_sync[1];
    active  = s_q.ctrl_en &&
              (s_q.mode == ofc_pkg::MODE_OCTAL ||
               s_q.mode == ofc_pkg::MODE_OVERLAY);
    op_now  = (s_q.cyc == 3'h0) ? s_q.hi_byte : s_q.op;
    need    = cycles_of(op_now);
    cyc_inc = 3'(s_q.cyc + 3'h1);
    word    = {s_q.hi_byte, s_q.dq_s1};
    sr0_clr = 8'h00;
    evt     = '0;
    irq_clr = '0;
    apb_wr  = 1'b0;
    s_d.ex_done = 1'b0;

    case (s_q.lnk)
      ofc_pkg::LNK_IDLE:
      begin
        if (!cs_hi && active)
        begin
          s_d.lnk = ofc_pkg::LNK_CMD;
          s_d.cyc = 3'h0;
        end
      end
      ofc_pkg::LNK_CMD:
      begin
        if (ck_rise)
        begin
          s_d.hi_byte = s_q.dq_s1;
        end
        else if (ck_fall)
        begin
          s_d.cyc = cyc_inc;
          if (s_q.cyc == 3'h0)
          begin
            s_d.op  = s_q.hi_byte;
            s_d.arg = s_q.dq_s1;
          end
          if (need == ofc_pkg::CYC_NONE)
          begin
            evt[ofc_pkg::IRQ_BADOP] = 1'b1;
            s_d.lnk = ofc_pkg::LNK_WAIT;
          end
          else if (cyc_inc == need)
          begin
            s_d.ex_done = 1'b1;
            s_d.ex_op   = op_now;
            s_d.ex_word = word;
            evt[ofc_pkg::IRQ_DONE] = 1'b1;
            s_d.lnk = ofc_pkg::LNK_WAIT;
            case (op_now)
              ofc_pkg::OP_ARRAY_READ:
              begin
                s_d.arr_addr = (s_q.cyc == 3'h0) ? s_q.dq_s1 : s_q.arg;
                s_d.arr_ovl  = (s_q.mode == ofc_pkg::MODE_OVERLAY);
                s_d.rsp_pend = 1'b1;
                s_d.lnk = ofc_pkg::LNK_RESP;
              end
              ofc_pkg::OP_ENTER_SPI:
              begin
                s_d.mode = ofc_pkg::MODE_SPI;
                evt[ofc_pkg::IRQ_MODE] = 1'b1;
              end
              ofc_pkg::OP_SOFT_RESET:
              begin
                sr0_clr = ofc_pkg::SR0_SRST_CLR;
                if (s_q.mode == ofc_pkg::MODE_OVERLAY)
                begin
                  s_d.mode = ofc_pkg::MODE_OCTAL;
                end
                evt[ofc_pkg::IRQ_SRST] = 1'b1;
              end
              ofc_pkg::OP_DEEP_SLEEP:
              begin
                s_d.mode = ofc_pkg::MODE_SLEEP;
                evt[ofc_pkg::IRQ_MODE] = 1'b1;
              end
              ofc_pkg::OP_STATUS_READ:
              begin
                s_d.rsp = {8'h00, s_q.sr0};
                s_d.lnk = ofc_pkg::LNK_RESP;
              end
              ofc_pkg::OP_FLAG_CLEAR: sr0_clr = ofc_pkg::SR0_FAIL_MASK;
              ofc_pkg::OP_POR_WRITE:   s_d.por_timer = word;
              ofc_pkg::OP_ICFG_WRITE:  s_d.icfg = word;
              ofc_pkg::OP_ISTAT_WRITE: s_d.istat = word;
              ofc_pkg::OP_VCFGA_WRITE: s_d.vcfg_a = word;
              ofc_pkg::OP_VCFGB_WRITE: s_d.vcfg_b = word;
              ofc_pkg::OP_POR_READ,
              ofc_pkg::OP_ICFG_READ,
              ofc_pkg::OP_ISTAT_READ,
              ofc_pkg::OP_VCFGA_READ,
              ofc_pkg::OP_VCFGB_READ:
              begin
                s_d.lnk = ofc_pkg::LNK_RESP;
                case (op_now)
                  ofc_pkg::OP_POR_READ:   s_d.rsp = s_q.por_timer;
                  ofc_pkg::OP_ICFG_READ:  s_d.rsp = s_q.icfg;
                  ofc_pkg::OP_ISTAT_READ: s_d.rsp = s_q.istat;
                  ofc_pkg::OP_VCFGA_READ: s_d.rsp = s_q.vcfg_a;
                  default:                s_d.rsp = s_q.vcfg_b;
                endcase
              end
              default: s_d.lnk = ofc_pkg::LNK_WAIT;
            endcase
          end
        end
      end
      ofc_pkg::LNK_RESP:
      begin
        // array word one cycle after address
        if (s_q.rsp_pend)
        begin
          s_d.rsp      = i_array_data;
          s_d.rsp_pend = 1'b0;
        end
        if (ck_rise)
        begin
          s_d.rsp_lo = 1'b1;
        end
        else if (ck_fall && s_q.rsp_lo)
        begin
          s_d.lnk = ofc_pkg::LNK_WAIT;
        end
      end
      ofc_pkg::LNK_WAIT: s_d.lnk = ofc_pkg::LNK_WAIT;
      default:           s_d.lnk = ofc_pkg::LNK_IDLE;
    endcase

    // deselect ends any frame, even a short one
    if (cs_hi)
    begin
      s_d.lnk      = ofc_pkg::LNK_IDLE;
      s_d.rsp_lo   = 1'b0;
      s_d.rsp_pend = 1'b0;
    end
    s_d.dq_oe_n = (s_d.lnk != ofc_pkg::LNK_RESP);
    s_d.dq_out  = s_d.rsp_lo ? s_d.rsp[7:0] : s_d.rsp[15:8];

    if (i_overlay_enter && s_d.mode == ofc_pkg::MODE_OCTAL)
    begin
      s_d.mode = ofc_pkg::MODE_OVERLAY;
    end

    // apb: read data prepared in setup, write at access
    if (i_psel && !i_penable)
    begin
      {s_d.pslverr, s_d.prdata} = rd_mux(i_paddr, s_q);
    end
    apb_wr = i_psel && i_penable && i_pwrite && !s_q.pslverr;
    if (apb_wr)
    begin
      case (i_paddr)
        ofc_pkg::A_IRQ_CLR: irq_clr = i_pwdata[ofc_pkg::IRQ_W-1:0];
        ofc_pkg::A_IRQ_EN:  s_d.irq_en = i_pwdata[ofc_pkg::IRQ_W-1:0];
        ofc_pkg::A_CTRL:
        begin
          s_d.ctrl_en = i_pwdata[ofc_pkg::CTRL_EN_BIT];
          if (i_pwdata[ofc_pkg::CTRL_RELEASE_BIT] &&
              s_q.mode != ofc_pkg::MODE_OCTAL)
          begin
            s_d.mode = ofc_pkg::MODE_OCTAL;
            evt[ofc_pkg::IRQ_MODE] = 1'b1;
          end
        end
        default: s_d.irq_en = s_q.irq_en;
      endcase
    end

    // hardware set wins over a clear in the same cycle
    s_d.sr0     = (s_q.sr0 & ~sr0_clr) | i_sr0_set;
    s_d.irq_sts = (s_q.irq_sts & ~irq_clr) | evt;
    s_d.irq     = |(s_d.irq_sts & s_d.irq_en);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q           <= '0;
      s_q.cs_sync   <= 2'h3;
      s_q.lnk       <= ofc_pkg::LNK_IDLE;
      s_q.mode      <= ofc_pkg::MODE_OCTAL;
      s_q.dq_oe_n   <= 1'b1;
      s_q.sr0       <= ofc_pkg::RST_SR0;
      s_q.por_timer <= ofc_pkg::RST_POR_TIMER;
      s_q.icfg      <= ofc_pkg::RST_ICFG;
      s_q.istat     <= ofc_pkg::RST_ISTAT;
      s_q.vcfg_a    <= ofc_pkg::RST_VCFG_A;
      s_q.vcfg_b    <= ofc_pkg::RST_VCFG_B;
      s_q.ctrl_en   <= ofc_pkg::RST_CTRL_EN;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_dq            = s_q.dq_out;
  assign o_dq_oe_n       = s_q.dq_oe_n;
  assign o_array_addr    = s_q.arr_addr;
  assign o_array_overlay = s_q.arr_ovl;
  assign o_spi_mode      = (s_q.mode == ofc_pkg::MODE_SPI);
  assign o_deep_sleep    = (s_q.mode == ofc_pkg::MODE_SLEEP);
  assign o_overlay       = (s_q.mode == ofc_pkg::MODE_OVERLAY);
  assign o_sr0           = s_q.sr0;
  assign o_poweron_timer = s_q.por_timer;
  assign o_vcfg_a        = s_q.vcfg_a;
  assign o_vcfg_b        = s_q.vcfg_b;
  assign o_prdata        = s_q.prdata;
  assign o_pready        = 1'b1;
  assign o_pslverr       = s_q.pslverr & i_psel & i_penable;
  assign o_irq           = s_q.irq;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_exec(logic [7:0] op);
    s_q.ex_done && s_q.ex_op == op;
  endsequence

  sequence s_resp_start;
    s_q.lnk == ofc_pkg::LNK_RESP && s_q.rsp_pend;
  endsequence

  property p_array_word;
    s_resp_start |=> s_q.rsp == $past(i_array_data);
  endproperty
  a_array_word: assert property (p_array_word)
    else $error("array word not returned");

  property p_spi_entry;
    s_exec(ofc_pkg::OP_ENTER_SPI) |-> o_spi_mode && !o_deep_sleep;
  endproperty
  a_spi_entry: assert property (p_spi_entry)
    else $error("serial mode not entered");

  property p_overlay_exit;
    s_exec(ofc_pkg::OP_SOFT_RESET) |-> !o_overlay;
  endproperty
  a_overlay_exit: assert property (p_overlay_exit)
    else $error("overlay still active after soft reset");

  property p_srst_clear;
    s_exec(ofc_pkg::OP_SOFT_RESET) ##0 $past(i_sr0_set) == 8'h00
      |-> (s_q.sr0 & ofc_pkg::SR0_SRST_CLR) == 8'h00;
  endproperty
  a_srst_clear: assert property (p_srst_clear)
    else $error("status bits survive soft reset");

  property p_sleep;
    s_exec(ofc_pkg::OP_DEEP_SLEEP)
      |-> o_deep_sleep ##1 s_q.lnk != ofc_pkg::LNK_CMD;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("deep sleep not entered");

  property p_status_word;
    s_exec(ofc_pkg::OP_STATUS_READ)
      |-> s_q.rsp == {8'h00, $past(s_q.sr0)} && !o_dq_oe_n;
  endproperty
  a_status_word: assert property (p_status_word)
    else $error("status word not driven");

  property p_flag_clear;
    s_exec(ofc_pkg::OP_FLAG_CLEAR) ##0 $past(i_sr0_set) == 8'h00
      |-> (s_q.sr0 & ofc_pkg::SR0_FAIL_MASK) == 8'h00;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("failure flags not cleared");

  property p_por_write;
    s_exec(ofc_pkg::OP_POR_WRITE) |-> o_poweron_timer == s_q.ex_word;
  endproperty
  a_por_write: assert property (p_por_write)
    else $error("power-on timer not loaded");

  property p_cfg_write;
    s_exec(ofc_pkg::OP_VCFGB_WRITE)
      |-> o_vcfg_b == s_q.ex_word && $stable(o_vcfg_a);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config one not loaded alone");

  property p_reg_read;
    s_exec(ofc_pkg::OP_VCFGA_READ) |-> s_q.rsp == o_vcfg_a
      ##1 o_dq == s_q.rsp[15:8] || s_q.lnk == ofc_pkg::LNK_IDLE;
  endproperty
  a_reg_read: assert property (p_reg_read)
    else $error("config zero not returned");

  property p_irq_level;
    ##1 o_irq == |(s_q.irq_sts & s_q.irq_en);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level mismatch");

endmodule // ofc_txn_decoder

// [tb_top.sv]
/*
  self-checking bench of the octal transaction decoder: apb tasks and
  link transactions through the host model.
  assumes zero-wait apb and an array that answers combinationally.
*/
`timescale 1ns/1ps

module tb_top;
  logic        clk;
  logic        rst_n = 1'b0;
  logic        ck;
  logic        cs_n;
  logic [7:0]  hdq;
  logic [7:0]  dq;
  logic        oe_n;
  logic [7:0]  aadr;
  logic [15:0] adat;
  logic        aovl;
  logic [15:0] por_o;
  logic [15:0] vca;
  logic [15:0] vcb;
  logic [7:0]  sset = 8'h00;
  logic        ovin = 1'b0;
  logic        spi;
  logic        slp;
  logic        ovl;
  logic [7:0]  sr0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic        prdy;
  logic        perr_o;
  logic        irq;
  logic [31:0] rdat;
  logic        perr;
  logic [15:0] r;
  int          n_fail = 0;
  int          num_checks = 0;

  localparam logic [7:0] WOP [5] = '{ofc_pkg::OP_POR_WRITE,
    ofc_pkg::OP_ICFG_WRITE, ofc_pkg::OP_ISTAT_WRITE,
    ofc_pkg::OP_VCFGA_WRITE, ofc_pkg::OP_VCFGB_WRITE};
  localparam logic [7:0] ROP [5] = '{ofc_pkg::OP_POR_READ,
    ofc_pkg::OP_ICFG_READ, ofc_pkg::OP_ISTAT_READ,
    ofc_pkg::OP_VCFGA_READ, ofc_pkg::OP_VCFGB_READ};
  localparam logic [11:0] ADR [5] = '{ofc_pkg::A_POR, ofc_pkg::A_ICFG,
    ofc_pkg::A_ISTAT, ofc_pkg::A_VCFG_A, ofc_pkg::A_VCFG_B};

  // array word mirrors its address so every byte is traceable
  assign adat = {aadr, ~aadr};

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ofc_host_model host_u (
    .i_clk_sys (clk),
    .i_dq      (dq),
    .i_dq_oe_n (oe_n),
    .o_ck      (ck),
    .o_cs_n    (cs_n),
    .o_dq      (hdq)
  );

  ofc_txn_decoder dut_u (
    .i_clk_sys (clk), .i_rst_n (rst_n), .i_ck (ck), .i_cs_n (cs_n),
    .i_dq (hdq), .o_dq (dq), .o_dq_oe_n (oe_n), .o_array_addr (aadr),
    .o_array_overlay (aovl), .i_array_data (adat), .i_sr0_set (sset),
    .i_overlay_enter (ovin), .o_spi_mode (spi), .o_deep_sleep (slp),
    .o_overlay (ovl), .o_sr0 (sr0), .o_poweron_timer (por_o),
    .o_vcfg_a (vca), .o_vcfg_b (vcb), .i_psel (psel), .i_penable (pen),
    .i_pwrite (pwr),
    .i_paddr (padr), .i_pwdata (pwd), .o_prdata (prd), .o_pready (prdy),
    .o_pslverr (perr_o), .o_irq (irq)
  );

  function automatic logic [15:0] val(input int i);
    return 16'hA50F + 16'(16'h1111 * i);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (prdy !== 1'b1 && k < 50);
    rdat = prd;
    perr = perr_o;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] s, input logic o);
    @(posedge clk);
    sset <= s;
    ovin <= o;
    @(posedge clk);
    sset <= 8'h00;
    ovin <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, ofc_pkg::A_MODE, 32'h0);
    chk("mode reset", 32'h1, rdat);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, perr});
    for (int i = 0; i < 5; i++)
    begin
      host_u.txn(WOP[i], 8'h00, 4, val(i), 1'b0, r);
      host_u.txn(ROP[i], 8'h00, 4, 16'h0000, 1'b1, r);
      chk("link read", {16'h0, val(i)}, {16'h0, r});
      apb(1'b0, ADR[i], 32'h0);
      chk("apb view", {16'h0, val(i)}, rdat);
    end
    chk("timer pins", {16'h0, val(0)}, {16'h0, por_o});
    chk("cfg a pins", {16'h0, val(3)}, {16'h0, vca});
    chk("cfg b pins", {16'h0, val(4)}, {16'h0, vcb});
    $display("test registers done");
    host_u.txn(ofc_pkg::OP_ARRAY_READ, 8'h5C, 1, 16'h0, 1'b1, r);
    chk("array read", 32'h5CA3, {16'h0, r});
    chk("array plain", 32'h0, {31'h0, aovl});
    pulse(8'hFF, 1'b0);
    host_u.txn(ofc_pkg::OP_STATUS_READ, 8'h00, 2, 16'h0, 1'b1, r);
    chk("status read", 32'h00FF, {16'h0, r});
    apb(1'b1, ofc_pkg::A_IRQ_CLR, 32'hF);
    apb(1'b1, ofc_pkg::A_IRQ_EN, 32'h2);
    host_u.txn(ofc_pkg::OP_FLAG_CLEAR, 8'h00, 1, 16'h0, 1'b0, r);
    chk("flag clear", 32'hC7, {24'h0, sr0});
    chk("irq masked", 32'h0, {31'h0, irq});
    host_u.txn(8'h55, 8'h00, 1, 16'h0, 1'b0, r);
    chk("irq bad op", 32'h1, {31'h0, irq});
    apb(1'b0, ofc_pkg::A_IRQ_STS, 32'h0);
    chk("sts bad op", 32'h2, rdat & 32'h2);
    apb(1'b1, ofc_pkg::A_IRQ_CLR, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test status and irq done");
    pulse(8'hFF, 1'b1);
    chk("overlay in", 32'h1, {31'h0, ovl});
    host_u.txn(ofc_pkg::OP_ARRAY_READ, 8'h33, 1, 16'h0, 1'b1, r);
    chk("overlay read", 32'h33CC, {16'h0, r});
    chk("overlay flag", 32'h1, {31'h0, aovl});
    host_u.txn(ofc_pkg::OP_SOFT_RESET, 8'h00, 1, 16'h0, 1'b0, r);
    chk("soft reset sr0", 32'hC4, {24'h0, sr0});
    chk("overlay exit", 32'h0, {31'h0, ovl});
    host_u.txn(ofc_pkg::OP_ARRAY_READ, 8'h5C, 1, 16'h0, 1'b1, r);
    chk("array after exit", 32'h0, {31'h0, aovl});
    host_u.txn(ofc_pkg::OP_DEEP_SLEEP, 8'h00, 3, 16'h0, 1'b0, r);
    chk("deep sleep", 32'h1, {31'h0, slp});
    host_u.txn(ofc_pkg::OP_VCFGA_WRITE, 8'h00, 4, 16'hDEAD, 1'b0, r);
    apb(1'b0, ofc_pkg::A_VCFG_A, 32'h0);
    chk("asleep ignores", {16'h0, val(3)}, rdat);
    apb(1'b1, ofc_pkg::A_CTRL, 32'h3);
    host_u.txn(ofc_pkg::OP_ENTER_SPI, 8'h00, 3, 16'h0, 1'b0, r);
    chk("spi mode", 32'h1, {31'h0, spi});
    apb(1'b0, ofc_pkg::A_MODE, 32'h0);
    chk("mode spi", 32'h4, rdat & 32'hF);
    $display("test modes done");
    complete_run();
  end

  // the tests need about 1,000 clocks; allow thirty times that
  initial
  begin
    #3000000;
    n_fail++;
    complete_run();
  end

endmodule // tb_top
